// File: core/rxst_pkg.sv
// Shared constants, field positions and carrier types for the receive status block
package rxst_pkg;
	// Serial register addresses
	localparam logic [7:0] RXST_ADDR_RXA = 8'hc5;
	localparam logic [7:0] RXST_ADDR_STATUS = 8'hc6;
	localparam logic [7:0] RXST_ADDR_MODE = 8'hc7;
	localparam logic [7:0] RXST_ADDR_PROG = 8'hc8;
	localparam logic [7:0] RXST_ADDR_RXB = 8'hc9;
	localparam logic [7:0] RXST_ADDR_TONES = 8'hcc;
	localparam logic [7:0] RXST_ADDR_MASK = 8'hce;

	// Status word bit positions
	localparam int RXST_ST_IRQ = 15;
	localparam int RXST_ST_INBAND = 13;
	localparam int RXST_ST_XTSET = 12;
	localparam int RXST_ST_CTCSS = 11;
	localparam int RXST_ST_DCS = 10;
	localparam int RXST_ST_EOD = 7;
	localparam int RXST_ST_XFER = 6;
	localparam int RXST_ST_CRC = 5;
	localparam int RXST_ST_R2400 = 4;
	localparam int RXST_ST_R1200 = 3;
	localparam int RXST_ST_PROG = 0;
	// Bits cleared by a status read
	localparam logic [15:0] RXST_ST_RDCLR = 16'hfffe;

	// Mode control bits
	localparam int RXST_MD_RX = 0;
	localparam int RXST_MD_TX = 1;
	localparam int RXST_MD_TYPE0 = 2;
	localparam int RXST_MD_EODREQ = 9;

	// Reset values
	localparam logic [15:0] RXST_STATUS_RST = 16'h0001;
	localparam logic [15:0] RXST_MODE_RST = 16'h0000;
	localparam logic [15:0] RXST_MASK_RST = 16'h0000;

	// Tone codes
	localparam logic [5:0] RXST_TONE_NONE = 6'h00;
	localparam logic [5:0] RXST_TONE_INVALID = 6'h37;
	localparam logic [2:0] RXST_SP_NONE = 3'h0;
	localparam logic [2:0] RXST_SP_DCS = 3'h2;
	localparam logic [2:0] RXST_SP_DCS_INV = 3'h3;
	localparam logic [2:0] RXST_SP_TURNOFF = 3'h5;
	localparam logic [2:0] RXST_SP_MAINT = 3'h6;
	localparam logic [7:0] RXST_ALLCALL = 8'h40;

	// Serial frame layout
	localparam logic [4:0] RXST_ADDR_LAST = 5'd7;
	localparam logic [4:0] RXST_FRAME_LAST = 5'd23;

	// Programming completion time
	localparam int RXST_PROG_TIME_US = 250;
	localparam int RXST_CLK_MHZ = 20;
	localparam int RXST_PROG_CYCLES = RXST_PROG_TIME_US * RXST_CLK_MHZ;

	typedef struct packed {
		logic pair_valid;
		logic [15:0] pair;
		logic quad_valid;
		logic [31:0] quad;
		logic is_head;
		logic last;
		logic crc_done;
		logic crc_bad;
		logic sync_valid;
		logic head_ok;
		logic rate_high;
	} rxst_rx_t;

	typedef struct packed {
		logic need_data;
		logic last_bit;
		logic [2:0] fmt;
	} rxst_tx_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [3:0] sel_hi;
		logic [3:0] sel_lo;
	} rxst_xt_t;

	typedef struct packed {
		logic [5:0] code;
		logic [2:0] special;
		logic [4:0] inband;
		logic ctcss_en;
		logic dcs_en;
		logic xt_en;
		logic inband_en;
	} rxst_tone_t;

	function automatic logic rxst_is_write(input logic [7:0] a);
		return (a == RXST_ADDR_PROG) || (a == RXST_ADDR_MODE) || (a == RXST_ADDR_MASK);
	endfunction

	function automatic logic rxst_is_dcs(input logic [2:0] s);
		return (s == RXST_SP_DCS) || (s == RXST_SP_DCS_INV) || (s == RXST_SP_TURNOFF);
	endfunction
endpackage

// File: core/rxst_tsync.sv
// Toggle synchroniser turning a far-domain toggle into a one-cycle pulse
`timescale 1ns/10ps
module rxst_tsync import rxst_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Toggle in, pulse out
	input wire logic tgl,
	output logic pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} rxst_ts_t;

	rxst_ts_t q;
	rxst_ts_t d;

	always_comb begin
		d.s1 = tgl;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pulse = q.s2 ^ q.s3;
endmodule

// File: core/rxst_top.sv
// Receive status, receive data and tone status registers behind the serial control port
// Behaviour
// - Rx end flag with transfer flag, CRC updated
// - Tx end flag after final modem bit
// - Unsized Tx end needs end-of-data request bit
// - Transfer flag: Tx wants data, Rx ready
// - Types four/five check updates block error flag
// - Rate bits: none, low, high, reserved
// - Rate on head, and also on sync if type0
// - Programming write clears flag, timer sets it
// - Two words hold latest two or four bytes
// - New receive data overwrites unread data
// - Second word: selective tones high, address low
// - Four-tone update only on own or all-call address
// - Parse head, enable automatic decoding types 3-5
// - Six-bit tone index, zero none, 55 invalid
// - Tone index change flags, except none-to-invalid
// - Five-bit in-band index, change sets flag
// - Special field codes, clears tone index byte
// - Special field change sets digital or tone bit
// - Disabled fields zero, word zero in transmit
// - Code loss and recovery raise events
// - Status read clears bits one to fifteen
// - Enabled status change sets summary bit
`timescale 1ns/10ps
module rxst_top import rxst_pkg::*; #(
	parameter int PROG_CYCLES = RXST_PROG_CYCLES
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial control port
	input wire logic serial_clk,
	input wire logic csn,
	input wire logic mosi,
	output logic miso,
	output logic irq_n,
	// Modem events
	input wire rxst_rx_t rx,
	input wire rxst_tx_t tx,
	// Four-tone decoder
	input wire rxst_xt_t xt,
	input wire logic [7:0] dev_addr,
	// Sub-audio and in-band detectors
	input wire rxst_tone_t tone,
	// Controls to the rest of the device
	output logic rx_mode,
	output logic tx_mode,
	output logic [15:0] prog_word,
	output logic prog_stb,
	output logic auto_decode,
	output logic [2:0] head_type,
	output logic [7:0] head_size
);
	// Reset release
	logic [1:0] rst_sh_q;
	logic rst_sync_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sh_q <= 2'b00;
		end else begin
			rst_sh_q <= {rst_sh_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sh_q[1];

	// Link side, clocked by the host's serial clock
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] sh;
		logic [15:0] wdata;
		logic a_tgl;
		logic w_tgl;
	} rxst_link_t;

	rxst_link_t lq;
	rxst_link_t ld;
	logic link_rst_n;
	logic [15:0] rd_word_q;
	// Bit counter kept apart: chip select clears it on its own reset
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;

	// Frame state ends with chip select; toggles survive since they are flops
	// that only change on edges inside a frame
	always_comb begin
		ld = lq;
		cnt_d = cnt_q;
		ld.sh = {lq.sh[14:0], mosi};
		if (cnt_q != RXST_FRAME_LAST) begin
			cnt_d = cnt_q + 5'd1;
		end
		if (cnt_q == RXST_ADDR_LAST) begin
			ld.addr = {lq.sh[6:0], mosi};
			ld.a_tgl = ~lq.a_tgl;
		end
		if (cnt_q == RXST_FRAME_LAST && rxst_is_write(lq.addr)) begin
			ld.wdata = {lq.sh[14:0], mosi};
			ld.w_tgl = ~lq.w_tgl;
		end
	end

	logic cnt_rst_n;
	assign cnt_rst_n = rst_sync_n & ~csn;
	assign link_rst_n = rst_sync_n;

	// Counter restarts on each frame; the rest keeps its value across frames
	always_ff @(posedge serial_clk or negedge cnt_rst_n) begin
		if (!cnt_rst_n) begin
			cnt_q <= 5'd0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lq.addr <= 8'h00;
			lq.sh <= 16'h0000;
			lq.wdata <= 16'h0000;
			lq.a_tgl <= 1'b0;
			lq.w_tgl <= 1'b0;
		end else if (!csn) begin
			lq.addr <= ld.addr;
			lq.sh <= ld.sh;
			lq.wdata <= ld.wdata;
			lq.a_tgl <= ld.a_tgl;
			lq.w_tgl <= ld.w_tgl;
		end
	end

	// Read word is held steady by the core while the host clocks it out;
	// the host pauses after the address byte so the core can load it
	logic [3:0] bit_sel;
	assign bit_sel = 4'(RXST_FRAME_LAST - cnt_q);
	assign miso = (!csn && cnt_q > RXST_ADDR_LAST) ? rd_word_q[bit_sel] : 1'b0;

	// Crossing into the system clock
	logic addr_ev;
	logic wr_ev;

	rxst_tsync u_addr_sync (
		.clk(clk),
		.rst_n(rst_sync_n),
		.tgl(lq.a_tgl),
		.pulse(addr_ev)
	);

	rxst_tsync u_wr_sync (
		.clk(clk),
		.rst_n(rst_sync_n),
		.tgl(lq.w_tgl),
		.pulse(wr_ev)
	);

	// Core state
	typedef struct packed {
		logic [15:0] status;
		logic [15:0] word_a;
		logic [15:0] word_b;
		logic [15:0] mask;
		logic [15:0] mode;
		logic [15:0] rd_word;
		logic [15:0] tone_prev;
		logic [15:0] prog_word;
		logic [31:0] prog_cnt;
		logic prog_busy;
		logic prog_stb;
		logic [2:0] fmt_type;
		logic auto_dec;
		logic [7:0] size;
	} rxst_core_t;

	rxst_core_t q;
	rxst_core_t d;

	logic [15:0] tone_word;
	logic [15:0] set_v;
	logic [15:0] clr_v;
	logic [2:0] sp_vis;
	logic [5:0] code_vis;
	logic [4:0] inb_vis;
	logic in_rx;
	logic in_tx;
	logic xt_match;

	assign in_rx = q.mode[RXST_MD_RX];
	assign in_tx = q.mode[RXST_MD_TX];
	assign xt_match = (xt.addr == dev_addr) || (xt.addr == RXST_ALLCALL);

	// Visible tone fields
	always_comb begin
		sp_vis = RXST_SP_NONE;
		if (rxst_is_dcs(tone.special) && tone.dcs_en) begin
			sp_vis = tone.special;
		end else if (tone.special == RXST_SP_MAINT && tone.xt_en) begin
			sp_vis = tone.special;
		end
		code_vis = tone.ctcss_en ? tone.code : RXST_TONE_NONE;
		if (sp_vis != RXST_SP_NONE) begin
			code_vis = RXST_TONE_NONE;
		end
		inb_vis = tone.inband_en ? tone.inband : 5'h00;
		tone_word = {inb_vis, sp_vis, 2'b00, code_vis};
		if (in_tx) begin
			tone_word = 16'h0000;
		end
	end

	always_comb begin
		d = q;
		d.prog_stb = 1'b0;
		set_v = 16'h0000;
		clr_v = 16'hffff;

		// Register read: load the word, then clear status on read
		if (addr_ev && !rxst_is_write(lq.addr)) begin
			case (lq.addr)
				RXST_ADDR_RXA: d.rd_word = q.word_a;
				RXST_ADDR_RXB: d.rd_word = q.word_b;
				RXST_ADDR_STATUS: d.rd_word = q.status;
				RXST_ADDR_TONES: d.rd_word = tone_word;
				default: d.rd_word = 16'h0000;
			endcase
			if (lq.addr == RXST_ADDR_STATUS) begin
				clr_v = ~RXST_ST_RDCLR;
			end
		end

		// Register writes
		if (wr_ev) begin
			case (lq.addr)
				RXST_ADDR_PROG: begin
					d.prog_word = lq.wdata;
					d.prog_stb = 1'b1;
					d.prog_busy = 1'b1;
					d.prog_cnt = 32'd0;
					clr_v[RXST_ST_PROG] = 1'b0;
				end
				RXST_ADDR_MODE: d.mode = lq.wdata;
				RXST_ADDR_MASK: d.mask = lq.wdata;
				default: d.mode = q.mode;
			endcase
		end

		// Programming completion timer
		if (q.prog_busy) begin
			d.prog_cnt = q.prog_cnt + 32'd1;
			if (q.prog_cnt == 32'(PROG_CYCLES - 1)) begin
				d.prog_busy = 1'b0;
				set_v[RXST_ST_PROG] = 1'b1;
			end
		end

		// Receive path; data is never held back for the host
		if (in_rx) begin
			if (rx.pair_valid) begin
				d.word_a = rx.pair;
				set_v[RXST_ST_XFER] = 1'b1;
			end
			if (rx.quad_valid) begin
				d.word_a = rx.quad[31:16];
				d.word_b = rx.quad[15:0];
				set_v[RXST_ST_XFER] = 1'b1;
				if (rx.is_head) begin
					d.fmt_type = rx.quad[18:16];
					d.size = rx.quad[15:8];
					d.auto_dec = (rx.quad[18:16] >= 3'd3) && (rx.quad[18:16] <= 3'd5);
				end
			end
			if (rx.last) begin
				set_v[RXST_ST_EOD] = 1'b1;
				set_v[RXST_ST_XFER] = 1'b1;
			end
			if (rx.last || (rx.crc_done && (q.fmt_type == 3'd4 || q.fmt_type == 3'd5))) begin
				set_v[RXST_ST_CRC] = rx.crc_bad;
				clr_v[RXST_ST_CRC] = 1'b0;
			end
			if ((q.mode[RXST_MD_TYPE0] && rx.sync_valid) || rx.head_ok) begin
				set_v[RXST_ST_R2400] = rx.rate_high;
				set_v[RXST_ST_R1200] = !rx.rate_high;
				clr_v[RXST_ST_R2400] = 1'b0;
				clr_v[RXST_ST_R1200] = 1'b0;
			end
			if (xt.valid && xt_match) begin
				d.word_b = {xt.sel_hi, xt.sel_lo, xt.addr};
				set_v[RXST_ST_XTSET] = 1'b1;
			end
		end

		// Transmit path
		if (in_tx) begin
			if (tx.need_data) begin
				set_v[RXST_ST_XFER] = 1'b1;
			end
			if (tx.last_bit) begin
				if (tx.fmt == 3'd0 || tx.fmt == 3'd2 || tx.fmt == 3'd3) begin
					set_v[RXST_ST_EOD] = q.mode[RXST_MD_EODREQ];
				end else begin
					set_v[RXST_ST_EOD] = 1'b1;
				end
			end
		end

		// Tone field changes
		if (tone_word[5:0] != q.tone_prev[5:0]) begin
			if (!(q.tone_prev[5:0] == RXST_TONE_NONE && tone_word[5:0] == RXST_TONE_INVALID)) begin
				set_v[RXST_ST_CTCSS] = !in_tx;
			end
		end
		if (tone_word[10:8] != q.tone_prev[10:8]) begin
			// Losing or regaining a digital code shows as a digital-code change
			if (rxst_is_dcs(tone_word[10:8]) || rxst_is_dcs(q.tone_prev[10:8])) begin
				set_v[RXST_ST_DCS] = !in_tx;
			end else begin
				set_v[RXST_ST_CTCSS] = !in_tx;
			end
		end
		if (tone_word[15:11] != q.tone_prev[15:11]) begin
			set_v[RXST_ST_INBAND] = !in_tx;
		end
		d.tone_prev = tone_word;

		// Summary bit from any enabled newly set bit
		if (|(set_v[14:0] & q.mask[14:0])) begin
			set_v[RXST_ST_IRQ] = 1'b1;
		end

		// Set wins over a read clear in the same cycle
		d.status = (q.status & clr_v) | set_v;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			q <= '0;
			q.status <= RXST_STATUS_RST;
			q.mode <= RXST_MODE_RST;
			q.mask <= RXST_MASK_RST;
		end else begin
			q <= d;
		end
	end

	assign rd_word_q = q.rd_word;
	assign irq_n = !(q.status[RXST_ST_IRQ] && q.mask[RXST_ST_IRQ]);
	assign rx_mode = q.mode[RXST_MD_RX];
	assign tx_mode = q.mode[RXST_MD_TX];
	assign prog_word = q.prog_word;
	assign prog_stb = q.prog_stb;
	assign auto_decode = q.auto_dec;
	assign head_type = q.fmt_type;
	assign head_size = q.size;
endmodule

// File: sim/rxst_assertions.sv
// Port-level checks for the receive status block
`timescale 1ns/10ps
module rxst_assertions import rxst_pkg::*; #(
	parameter int PROG_CYCLES = RXST_PROG_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial port
	input wire logic csn,
	input wire logic miso,
	input wire logic irq_n,
	// Modem events
	input wire rxst_rx_t rx,
	// Controls
	input wire logic rx_mode,
	input wire logic tx_mode,
	input wire logic [15:0] prog_word,
	input wire logic prog_stb,
	input wire logic auto_decode,
	input wire logic [2:0] head_type,
	input wire logic [7:0] head_size
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Heads only count in receive mode
	wire logic head_in = rx_mode && rx.is_head && rx.quad_valid && rx.head_ok;
	a_head_type: assert property (head_in |=> head_type == $past(rx.quad[18:16]))
		else $error("head type wrong");
	a_head_size: assert property (head_in |=> head_size == $past(rx.quad[15:8]))
		else $error("head size wrong");
	a_auto_types: assert property (
		head_in |=> auto_decode == ($past(rx.quad[18:16]) inside {3'h3, 3'h4, 3'h5}))
		else $error("auto decode wrong");
	a_head_hold: assert property (!head_in |=> $stable({head_type, head_size}))
		else $error("head fields moved");
	a_prog_pulse: assert property (prog_stb |=> !prog_stb)
		else $error("prog strobe too long");
	a_prog_word: assert property (
		$changed(prog_word) |-> (prog_stb || $past(prog_stb)) or (##1 prog_stb))
		else $error("prog word without strobe");
	a_miso_idle: assert property (csn |-> !miso)
		else $error("miso driven while idle");
	a_mode_frame: assert property ($changed({rx_mode, tx_mode}) |-> csn)
		else $error("mode moved inside a frame");
	c_head: cover property (head_in ##1 auto_decode);
	c_prog: cover property (prog_stb);
	c_irq: cover property (!irq_n);
endmodule
bind rxst_top rxst_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_rxst_assertions (
	.clk(clk), .rst_n(rst_n), .csn(csn), .miso(miso), .irq_n(irq_n), .rx(rx),
	.rx_mode(rx_mode), .tx_mode(tx_mode), .prog_word(prog_word), .prog_stb(prog_stb),
	.auto_decode(auto_decode), .head_type(head_type), .head_size(head_size));

// File: sim/rxst_host.sv
// Host controller model on the serial control port
`timescale 1ns/10ps
module rxst_host (
	// Serial port
	output logic serial_clk,
	output logic csn,
	output logic mosi,
	input wire logic miso
);
	initial begin
		serial_clk = 1'b0;
		csn = 1'b1;
		mosi = 1'b0;
	end
	// One register per frame; the clock only runs inside it
	task automatic xfer(input logic [7:0] a, input logic [15:0] w, output logic [15:0] r);
		logic [23:0] f;
		f = {a, w};
		csn = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			mosi = f[i];
			#3;
			if (i < 16) r[i] = miso;
			serial_clk = 1'b1;
			#3;
			serial_clk = 1'b0;
			// Core needs time to fetch the read word
			if (i == 16) #400;
		end
		#3;
		csn = 1'b1;
		mosi = ~mosi;
		#400;
	endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the receive status block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t %h %h", $time, (a), (b)); end end
module testbench;
	import rxst_pkg::*;
	localparam int PC = 40;
	localparam logic [7:0] ST = RXST_ADDR_STATUS;
	logic clk = 1'b0;
	logic rst_n;
	logic serial_clk, csn, mosi, miso, irq_n;
	rxst_rx_t rx;
	rxst_tx_t tx;
	rxst_xt_t xt;
	rxst_tone_t tone;
	logic [7:0] dev_addr;
	logic rx_mode, tx_mode, prog_stb, auto_decode;
	logic [15:0] prog_word;
	logic [2:0] head_type;
	logic [7:0] head_size;
	int mismatches = 0;
	int num_checks = 0;
	logic [13:0] tv [6] = '{14'h0037, 14'h000c, 14'h1a0c, 14'h1a80, 14'h1a00, 14'h1b80};
	logic [15:0] ts [6] = '{16'h0000, 16'h0800, 16'h2000, 16'h0c00, 16'h0400, 16'h0800};
	logic [7:0] xa [3] = '{8'h40, 8'h21, 8'h22};
	always #25 clk = ~clk;
	rxst_top #(.PROG_CYCLES(PC)) u_rxst_top (.clk(clk), .rst_n(rst_n), .serial_clk(serial_clk),
		.csn(csn), .mosi(mosi), .miso(miso), .irq_n(irq_n), .rx(rx), .tx(tx), .xt(xt),
		.dev_addr(dev_addr), .tone(tone), .rx_mode(rx_mode), .tx_mode(tx_mode),
		.prog_word(prog_word), .prog_stb(prog_stb), .auto_decode(auto_decode),
		.head_type(head_type), .head_size(head_size));
	rxst_host u_rxst_host (.serial_clk(serial_clk), .csn(csn), .mosi(mosi), .miso(miso));
	task automatic tally_and_finish();
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		logic [15:0] d;
		u_rxst_host.xfer(a, 16'h0000, d);
		`CHK(d & m, e & m)
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		logic [15:0] d;
		u_rxst_host.xfer(a, w, d);
	endtask
	task automatic pulse(input rxst_rx_t r, input rxst_tx_t t, input rxst_xt_t x);
		@(posedge clk);
		#2;
		rx = r;
		tx = t;
		xt = x;
		@(posedge clk);
		#2;
		rx = '0;
		xt = '0;
		tx.need_data = 1'b0;
		tx.last_bit = 1'b0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		logic [31:0] q;
		logic [15:0] w, d, bexp;
		rxst_rx_t r;
		rxst_tx_t t;
		rxst_xt_t x;
		int i;
		rst_n = 1'b0;
		rx = '0;
		tx = '0;
		xt = '0;
		tone = '0;
		dev_addr = 8'h21;
		void'($urandom(78));
		repeat (3) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (6) @(posedge clk);
		chk(ST, RXST_STATUS_RST, 16'hffff);
		chk(8'hc0, 16'h0000, 16'hffff);
		w = 16'($urandom);
		wr(RXST_ADDR_PROG, w);
		`CHK(prog_word, w)
		chk(ST, 16'h0000, 16'h0001);
		i = 0;
		do begin
			u_rxst_host.xfer(ST, 16'h0000, d);
			i++;
		end while (d[0] !== 1'b1 && i < 10);
		if (d[0] !== 1'b1) begin
			mismatches++;
			tally_and_finish();
		end
		wr(RXST_ADDR_MODE, 16'h0001);
		`CHK({rx_mode, tx_mode}, 2'b10)
		for (i = 0; i < 8; i++) begin
			q = $urandom;
			// Last head is type four, so the block check tests below count
			q[18:16] = 3'(i + 5);
			r = '0;
			r.quad_valid = 1'b1;
			r.is_head = 1'b1;
			r.head_ok = 1'b1;
			r.rate_high = i[0];
			r.quad = q;
			pulse(r, '0, '0);
			chk(RXST_ADDR_RXA, q[31:16], 16'hffff);
			chk(RXST_ADDR_RXB, q[15:0], 16'hffff);
			chk(ST, i[0] ? 16'h0011 : 16'h0009, 16'h0019);
			`CHK(head_type, q[18:16])
			`CHK(auto_decode, q[18:16] inside {3'h3, 3'h4, 3'h5})
		end
		bexp = q[15:0];
		r = '0;
		r.pair_valid = 1'b1;
		repeat (2) begin
			r.pair = 16'($urandom);
			pulse(r, '0, '0);
		end
		chk(RXST_ADDR_RXA, r.pair, 16'hffff);
		chk(ST, 16'h0040, 16'h0040);
		r = '0;
		r.last = 1'b1;
		r.crc_bad = 1'b1;
		pulse(r, '0, '0);
		chk(ST, 16'h00e0, 16'h00e0);
		r = '0;
		r.crc_done = 1'b1;
		for (i = 0; i < 2; i++) begin
			r.crc_bad = 1'b1;
			pulse(r, '0, '0);
			r.crc_bad = i[0];
			pulse(r, '0, '0);
			chk(ST, {10'h000, i[0], 5'h00}, 16'h0020);
		end
		// A bare sync only counts with type 0 formatting on
		for (i = 0; i < 2; i++) begin
			wr(RXST_ADDR_MODE, {13'h0000, i[0], 2'h1});
			r = '0;
			r.sync_valid = 1'b1;
			r.rate_high = 1'b1;
			pulse(r, '0, '0);
			chk(ST, {11'h000, i[0], 4'h0}, 16'h0018);
		end
		x = '0;
		for (i = 0; i < 3; i++) begin
			x.valid = 1'b1;
			x.addr = xa[i];
			x.sel_hi = 4'($urandom);
			x.sel_lo = 4'($urandom);
			pulse('0, '0, x);
			if (i < 2) bexp = {x.sel_hi, x.sel_lo, x.addr};
			chk(RXST_ADDR_RXB, bexp, 16'hffff);
			chk(ST, (i < 2) ? 16'h1000 : 16'h0000, 16'h1000);
		end
		for (i = 0; i < 7; i++) begin
			@(posedge clk);
			#2;
			if (i < 6) tone = {tv[i][5:0], tv[i][8:6], tv[i][13:9], 4'hf};
			else tone[3:0] = 4'h0;
			repeat (3) @(posedge clk);
			if (i < 6) chk(ST, ts[i], 16'h3c00);
			if (i < 6) chk(RXST_ADDR_TONES, {tv[i][13:6], 2'h0, tv[i][5:0]}, 16'hffff);
			else chk(RXST_ADDR_TONES, 16'h0000, 16'hffff);
		end
		@(posedge clk);
		#2;
		tone[3:0] = 4'hf;
		wr(RXST_ADDR_MODE, 16'h0002);
		`CHK({rx_mode, tx_mode}, 2'b01)
		chk(RXST_ADDR_TONES, 16'h0000, 16'hffff);
		for (i = 0; i < 4; i++) begin
			wr(RXST_ADDR_MODE, {6'h00, i[1], 9'h002});
			t = '0;
			t.last_bit = 1'b1;
			t.fmt = i[0] ? 3'h4 : 3'h2;
			pulse('0, t, '0);
			chk(ST, {8'h00, i[0] | i[1], 7'h00}, 16'h0080);
		end
		wr(RXST_ADDR_MASK, 16'h8040);
		t = '0;
		t.need_data = 1'b1;
		pulse('0, t, '0);
		`CHK(irq_n, 1'b0)
		chk(ST, 16'h8040, 16'h8040);
		`CHK(irq_n, 1'b1)
		tally_and_finish();
	end
endmodule
